// [fpc_host.v]
// Purpose: Host that loads a byte-wide passive configuration port from software.
// Assumes: Software feeds bytes over classic Wishbone; pins pass fpc_sync.
// Notes:   Data writes stall the bus while the holding byte is full.
// Functional notes
// R1: 4x clock per byte in decompression mode
// R2: Configuration clock kept at or below 100 MHz
// R3: Device picks power-on delay from select input
// R4: Device holds status low during power-on
// R5: Device pull-ups follow pull-up control input
// R6: Reset stage while request or status low
// R7: Device releases status, then accepts bytes
// R8: Host sends one byte per transfer after status
// R9: Plain mode latches bytes on rising edges
// R10: 4x mode latches every fourth edge
// R11: Keep clocking until completion line is high
// R12: Completion rise starts device initialization
// R13: Clock edges after completion have no effect
// R14: User start-up clock, 299 cycles, max 100 MHz
// R15: Init-done low in load, high in user mode
// R16: Host detects init-done rise as user mode
// R17: Device drops pull-ups in user mode
// R18: Clock and data driven, not floating, at end
// R19: Clock may pause indefinitely, no minimum rate
// R20: In 4x mode stop three cycles after latch
// R21: Data valid before first rising edge on resume
// R22: Error pulls status low; auto-restart releases it
// R23: Without auto-restart, request low 40 us
// R24: Request low in user mode resets device
// R25: Scheme select chooses byte-wide variant
// R26: Device ignores bus outside configuration stage
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_host #(
    parameter USR_MARGIN = 16   // Extra user clock cycles covering the enable delay
) (
    input  wire        clk_i,                  // System clock, 50 MHz
    input  wire        rst_i,                  // Synchronous reset, active high
    input  wire        wb_cyc_i,               // Wishbone cycle
    input  wire        wb_stb_i,               // Wishbone strobe
    input  wire        wb_we_i,                // Wishbone write enable
    input  wire [7:0]  wb_adr_i,               // Wishbone byte address
    input  wire [3:0]  wb_sel_i,               // Wishbone byte selects
    input  wire [31:0] wb_dat_i,               // Wishbone write data
    output reg  [31:0] wb_dat_o,               // Wishbone read data
    output reg         wb_ack_o,               // Wishbone acknowledge
    output reg         config_request_n_o,     // Configuration request, active low
    input  wire        status_open_drain_n_i,  // Device status line, low = reset/error
    input  wire        config_complete_i,      // Device completion line
    input  wire        init_done_i,            // Device init-done line
    output wire        config_clock_o,         // Configuration clock to device
    output reg  [7:0]  data_o,                 // Configuration byte bus
    output wire        user_startup_clock_o    // Optional start-up clock to device
);
    // One-hot states
    localparam [6:0] S_IDLE   = 7'h01;
    localparam [6:0] S_REQLOW = 7'h02;
    localparam [6:0] S_WAITST = 7'h04;
    localparam [6:0] S_LOAD   = 7'h08;
    localparam [6:0] S_INIT   = 7'h10;
    localparam [6:0] S_DONE   = 7'h20;
    localparam [6:0] S_ERROR  = 7'h40;
    localparam [15:0] REQ_LOW_M1 = `FPC_REQ_LOW_CYC - 1;
    localparam [9:0]  USR_CYC = `FPC_USR_INIT_CYC + USR_MARGIN;

    reg  [6:0]  state;
    reg  [6:0]  next_state;
    reg  [3:0]  ctrl;          // mode4x, use_init, uclk_en, autorst held
    reg         mode4x;        // Mode latched at start
    reg  [15:0] low_cnt;
    reg  [7:0]  hold;
    reg         hold_full;
    reg         have_byte;
    reg  [1:0]  ecnt;
    reg  [31:0] byte_cnt;
    reg         error;
    reg         init_prev;
    reg  [9:0]  ucnt;
    wire [2:0]  pins_s;
    wire        status_s = pins_s[0];
    wire        complete_s = pins_s[1];
    wire        init_s = pins_s[2];
    wire        cfg_rise;
    wire        usr_rise;

    // Pin inputs cross into the system clock domain
    fpc_sync #(
        .W   (3)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({init_done_i, config_complete_i, status_open_drain_n_i}),
        .q_o   (pins_s)
    );

    // Configuration clock runs only while a byte sits on the bus
    fpc_clk_div #(
        .HALF  (`FPC_HALF_CYC),
        .CW    (8)
    ) u_cfg_clk (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (have_byte),                         // R19
        .clk_o  (config_clock_o),                    // R2
        .rise_o (cfg_rise)
    );

    // Start-up clock runs through initialization when enabled
    fpc_clk_div #(
        .HALF  (`FPC_HALF_CYC),
        .CW    (8)
    ) u_usr_clk (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  ((state == S_INIT) & ctrl[2]),       // R14
        .clk_o  (user_startup_clock_o),
        .rise_o (usr_rise)
    );

    // Bus request decode
    wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = req & wb_we_i & wb_sel_i[0];
    wire feeding  = (state == S_REQLOW) | (state == S_WAITST) | (state == S_LOAD);
    wire data_wr  = wr & (wb_adr_i == `FPC_ADR_DATA);
    wire stall    = data_wr & feeding & hold_full;
    wire take     = req & ~stall;
    wire ctrl_wr  = wr & take & (wb_adr_i == `FPC_ADR_CTRL);
    wire start    = ctrl_wr & wb_dat_i[`FPC_CTRL_START];
    wire abort    = ctrl_wr & wb_dat_i[`FPC_CTRL_ABORT];
    wire load_now = (state == S_LOAD) & ~have_byte & hold_full & ~complete_s;
    wire [1:0] last_edge = mode4x ? `FPC_EDGES_4X : `FPC_EDGES_1X;
    wire byte_end = cfg_rise & have_byte & (ecnt == last_edge);

    // Read mux; unmapped addresses read zero
    function [31:0] rd_mux;
        input [7:0] adr;
        begin
            if (adr == `FPC_ADR_CTRL) begin
                rd_mux = {26'h0, ctrl, 2'h0};
            end else if (adr == `FPC_ADR_STATUS) begin
                rd_mux = {18'h0, (state == S_DONE), hold_full, init_s,
                          status_s, complete_s, error, 1'b0, state};
            end else if (adr == `FPC_ADR_COUNT) begin
                rd_mux = byte_cnt;
            end else begin
                rd_mux = 32'h0;
            end
        end
    endfunction

    // Wishbone slave: one-cycle answer, stalled only for a full holding byte
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= take;
            if (take & ~wb_we_i) begin
                wb_dat_o <= rd_mux(wb_adr_i);
            end
        end
    end

    // Control register; start latches the transfer mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= `FPC_CTRL_RESET;
            mode4x <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl <= wb_dat_i[`FPC_CTRL_AUTORST:`FPC_CTRL_MODE4X];
            end
            if (start) begin
                mode4x <= wb_dat_i[`FPC_CTRL_MODE4X];            // R1
            end
        end
    end

    // Next-state logic
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (start) begin
                    next_state = S_REQLOW;
                end
            end
            S_REQLOW: begin
                if (low_cnt == REQ_LOW_M1) begin
                    next_state = S_WAITST;                        // R23
                end
            end
            S_WAITST: begin
                if (status_s) begin
                    next_state = S_LOAD;                          // R7 R3 R4
                end
            end
            S_LOAD: begin
                if (~status_s) begin
                    next_state = ctrl[3] ? S_WAITST : S_ERROR;    // R22
                end else if (complete_s & ~have_byte) begin
                    next_state = S_INIT;                          // R11 R12
                end
            end
            S_INIT: begin
                if (ctrl[1] & init_s & ~init_prev) begin
                    next_state = S_DONE;                          // R16
                end else if (~ctrl[1] & (~ctrl[2] | (ucnt == USR_CYC))) begin
                    next_state = S_DONE;                          // R13 R14
                end
            end
            S_DONE: begin
                if (start) begin
                    next_state = S_REQLOW;                        // R24
                end
            end
            S_ERROR: begin
                if (start) begin
                    next_state = S_REQLOW;                        // R23
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (abort) begin
            next_state = S_IDLE;
        end
    end

    // State register and request line; low in idle and reset stage only
    always @(posedge clk_i) begin
        if (rst_i) begin
            state              <= S_IDLE;
            config_request_n_o <= 1'b0;
        end else begin
            state              <= next_state;
            config_request_n_o <= ~((next_state == S_IDLE) |
                                    (next_state == S_REQLOW));    // R6
        end
    end

    // Request low timer runs only in the reset stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt <= 16'h0;
        end else if (state == S_REQLOW) begin
            low_cnt <= low_cnt + 16'h1;
        end else begin
            low_cnt <= 16'h0;
        end
    end

    // Holding byte: software fills it, the loader drains it
    always @(posedge clk_i) begin
        if (rst_i) begin
            hold      <= 8'h00;
            hold_full <= 1'b0;
        end else if (start | abort) begin
            hold_full <= 1'b0;
        end else if (data_wr & take & feeding) begin
            hold      <= wb_dat_i[7:0];
            hold_full <= 1'b1;
        end else if (load_now | ~feeding) begin
            hold_full <= 1'b0;                                    // R26
        end
    end

    // Byte on the pins: set before the first rise, held for every edge of it
    always @(posedge clk_i) begin
        if (rst_i) begin
            data_o    <= 8'h00;
            have_byte <= 1'b0;
            ecnt      <= 2'h0;
        end else if (state != S_LOAD) begin
            have_byte <= 1'b0;                                    // R18
            ecnt      <= 2'h0;
        end else if (load_now) begin
            data_o    <= hold;                                    // R8 R21
            have_byte <= 1'b1;
        end else if (byte_end) begin
            have_byte <= 1'b0;                                    // R9 R10 R20
            ecnt      <= 2'h0;
        end else if (cfg_rise & have_byte) begin
            ecnt <= ecnt + 2'h1;                                  // R10
        end
    end

    // Bytes sent since the last start
    always @(posedge clk_i) begin
        if (rst_i | start) begin
            byte_cnt <= 32'h0;
        end else if (byte_end & (state == S_LOAD)) begin
            byte_cnt <= byte_cnt + 32'h1;
        end
    end

    // Sticky error; a fault in the start cycle still wins over the clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            error <= 1'b0;
        end else if ((state == S_LOAD) & ~status_s) begin
            error <= 1'b1;                                        // R22
        end else if (start) begin
            error <= 1'b0;
        end
    end

    // Init-done edge history and user clock cycle count
    always @(posedge clk_i) begin
        if (rst_i) begin
            init_prev <= 1'b0;
            ucnt      <= 10'h0;
        end else begin
            init_prev <= init_s;                                  // R15
            if (state != S_INIT) begin
                ucnt <= 10'h0;
            end else if (usr_rise & (ucnt != USR_CYC)) begin
                ucnt <= ucnt + 10'h1;                             // R14
            end
        end
    end
endmodule // fpc_host

// [fpc_map.vh]
// Purpose: Constants for the byte-wide configuration host controller.
// Assumes: 50 MHz system clock; Wishbone byte addresses, one word per register.
// Notes:   The request low time is kept in microseconds; its cycle count derives from it.
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// System clock rate
`define FPC_CLK_MHZ        50
// Register byte offsets
`define FPC_ADR_CTRL       8'h00
`define FPC_ADR_STATUS     8'h04
`define FPC_ADR_DATA       8'h08
`define FPC_ADR_COUNT      8'h0C
// Control register fields
`define FPC_CTRL_START     0
`define FPC_CTRL_ABORT     1
`define FPC_CTRL_MODE4X    2
`define FPC_CTRL_USE_INIT  3
`define FPC_CTRL_UCLK_EN   4
`define FPC_CTRL_AUTORST   5
`define FPC_CTRL_RESET     4'h0
// Status register fields
`define FPC_ST_STATE_LSB   0
`define FPC_ST_ERROR       8
`define FPC_ST_COMPLETE    9
`define FPC_ST_STATUS_PIN  10
`define FPC_ST_INIT_PIN    11
`define FPC_ST_HOLD_FULL   12
`define FPC_ST_USER_MODE   13
// Request line low time in microseconds and its cycle count
`define FPC_REQ_LOW_US     40
`define FPC_REQ_LOW_CYC    (`FPC_REQ_LOW_US * `FPC_CLK_MHZ)
// Half period of generated clocks, in system cycles (6.25 MHz)
`define FPC_HALF_CYC       4
// Index of the last configuration clock edge of a byte in plain and 4x modes
`define FPC_EDGES_1X       2'h0
`define FPC_EDGES_4X       2'h3
// User start-up clock cycles the device needs to reach user mode
`define FPC_USR_INIT_CYC   299

`endif

// [fpc_sync.v]
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are levels; pulses shorter than one cycle may be missed.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module fpc_sync #(
    parameter W = 1
) (
    input  wire         clk_i,   // System clock
    input  wire         rst_i,   // Synchronous reset, active high
    input  wire [W-1:0] d_i,     // Asynchronous inputs
    output reg  [W-1:0] q_o      // Synchronised outputs
);
    reg [W-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // fpc_sync

// [fpc_clk_div.v]
// Purpose: Gated clock divider producing a pin clock from the system clock.
// Assumes: HALF is at least 2 system cycles.
// Notes:   Stops only in the low phase, so a pause always parks the pin low.
`timescale 1ns/1ps
module fpc_clk_div #(
    parameter HALF = 4,
    parameter CW   = 8
) (
    input  wire clk_i,   // System clock
    input  wire rst_i,   // Synchronous reset, active high
    input  wire run_i,   // Allow the next rising edge
    output reg  clk_o,   // Divided clock to the pin
    output wire rise_o   // Pulse: pin rises at the next edge
);
    localparam [CW-1:0] HALF_M1 = HALF - 1;
    reg  [CW-1:0] cnt;
    wire          last = (cnt == HALF_M1);

    // The low phase is timed from run, so data set with run has a full half period
    assign rise_o = run_i & ~clk_o & last;

    // Phase counter; idle low resets the count
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt   <= {CW{1'b0}};
            clk_o <= 1'b0;
        end else if (clk_o) begin
            if (last) begin
                clk_o <= 1'b0;
                cnt   <= {CW{1'b0}};
            end else begin
                cnt <= cnt + 1'b1;
            end
        end else if (run_i) begin
            if (last) begin
                clk_o <= 1'b1;
                cnt   <= {CW{1'b0}};
            end else begin
                cnt <= cnt + 1'b1;
            end
        end else begin
            cnt <= {CW{1'b0}};
        end
    end
endmodule // fpc_clk_div

// [fpc_host_sva.sv]
// Purpose: Port-level assertions for the configuration host controller.
// Assumes: One clock domain; sees only the host's own ports.
// Notes:   The bind sits at the foot of this file.
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_host_sva (
    input wire        clk_i,                 // System clock
    input wire        rst_i,                 // Synchronous reset
    input wire        wb_cyc_i,              // Bus cycle
    input wire        wb_stb_i,              // Bus strobe
    input wire        wb_we_i,               // Bus write enable
    input wire [7:0]  wb_adr_i,              // Bus address
    input wire [31:0] wb_dat_o,              // Read data
    input wire        wb_ack_o,              // Acknowledge
    input wire        config_request_n_o,    // Request line
    input wire        config_complete_i,     // Completion line
    input wire        config_clock_o,        // Configuration clock
    input wire [7:0]  data_o,                // Byte bus
    input wire        user_startup_clock_o   // Start-up clock
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [11:0] low_cnt;
    // Cycles the request has been low; saturates, never wraps
    always @(posedge clk_i) begin
        if (rst_i || config_request_n_o) low_cnt <= 12'h000;
        else if (low_cnt != 12'hFFF) low_cnt <= low_cnt + 12'h001;
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_prompt_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o
        && wb_adr_i != `FPC_ADR_DATA) |=> wb_ack_o) else $error("register access not acked");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    unmapped_zero_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i == 8'h10) |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    clk_high_a: assert property ($rose(config_clock_o) |-> config_clock_o[*4] ##1 !config_clock_o)
        else $error("clock high phase wrong");
    data_setup_a: assert property ($rose(config_clock_o) |-> data_o == $past(data_o, 2))
        else $error("byte changed just before clock rise");
    req_low_a: assert property ($rose(config_request_n_o) |-> low_cnt >= 12'h7D0)
        else $error("request low pulse too short");
    clk_req_a: assert property ($rose(config_clock_o) |-> config_request_n_o)
        else $error("clock edge while request low");
    uclk_init_a: assert property ($rose(user_startup_clock_o) |-> config_request_n_o
        && config_complete_i) else $error("start-up clock before completion");
endmodule // fpc_host_sva

bind fpc_host fpc_host_sva fpc_host_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .config_request_n_o, .config_complete_i, .config_clock_o,
    .data_o, .user_startup_clock_o);

// [fpc_dev_model.sv]
// Purpose: Behavioural model of the byte-wide passive configuration port.
// Assumes: Options a real image would carry are bench inputs here.
// Notes:   Open-drain lines are shown already resolved against their pull-ups.
`timescale 1ns/1ps
module fpc_dev_model #(
    parameter IMG    = 6,    // Image length in bytes
    parameter POR_NS = 2000  // Power-on time, shortened for simulation
) (
    input  wire       config_request_n_i,    // Request, active low
    input  wire       config_clock_i,        // Configuration clock
    input  wire [7:0] data_i,                // Byte bus
    input  wire       user_startup_clock_i,  // Start-up clock
    input  wire       mode4x_i,              // Decompression mode
    input  wire       use_init_i,            // Init-done output enabled
    input  wire       autorst_i,             // Auto-restart after error
    input  wire       err_i,                 // Bench order: flag an error
    output reg        status_open_drain_n_o, // Status, low = reset or error
    output reg        config_complete_o,     // Completion line
    output reg        init_done_o            // Init-done line
);
    integer n_bytes, sum, edges, uclk_n;
    reg     por_done, err_hold;
    // Power-on stage; status is held low until it ends
    initial begin
        por_done = 1'b0;
        err_hold = 1'b0;
        #(POR_NS) por_done = 1'b1;
    end
    // Reset stage; release is slow so the host must wait for status
    always @(config_request_n_i or por_done or err_hold) begin
        if (!config_request_n_i || !por_done || err_hold) begin
            status_open_drain_n_o = 1'b0;
            config_complete_o = 1'b0;
            init_done_o = 1'b1;
            n_bytes = 0;
            sum = 0;
            edges = 0;
            uclk_n = 0;
        end else begin
            #1000;
            status_open_drain_n_o = config_request_n_i && por_done && !err_hold;
        end
    end
    // Byte capture; edges outside configuration are ignored
    always @(posedge config_clock_i) begin
        if (status_open_drain_n_o && config_request_n_i && !config_complete_o) begin
            edges = edges + 1;
            if (!mode4x_i || edges % 4 == 0) begin
                n_bytes = n_bytes + 1;
                sum = sum + data_i;
                if (use_init_i) init_done_o = 1'b0;
                if (n_bytes == IMG - 1) config_complete_o = 1'b1;
            end
        end
    end
    // Initialization ends some time after completion
    always @(posedge config_complete_o) begin
        #2000;
        init_done_o = 1'b1;
    end
    always @(posedge user_startup_clock_i)
        if (config_complete_o) uclk_n = uclk_n + 1;
    // Error handling; without auto-restart only a request pulse clears it
    always @(posedge err_i) begin
        err_hold = 1'b1;
        if (autorst_i) begin
            #20000;
            err_hold = 1'b0;
        end
    end
    always @(negedge config_request_n_i) err_hold = 1'b0;
endmodule // fpc_dev_model

// [fast_parallel_config_port_test.sv]
// Purpose: Self-checking bench for the configuration host controller.
// Assumes: Device model on the pins; bus tasks play the software.
// Notes:   Rows cover load modes; hand-written cases follow.
`timescale 1ns/1ps
`include "fpc_map.vh"
`define FPC_CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
module fast_parallel_config_port_test;
    localparam int IMG = 6;
    typedef struct packed {
        logic [2:0] mode;       // Start-up clock, init-done, 4x control bits
        logic [6:0] exp_state;  // State once loading has ended
    } fpc_row_t;
    fpc_row_t rows [5] = '{'{3'b000, 7'h20}, '{3'b001, 7'h20}, '{3'b010, 7'h20},
                           '{3'b100, 7'h20}, '{3'b011, 7'h20}};
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic        m4 = 0, ui = 0, ar = 0, err = 0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, q;
    wire  [31:0] wb_dat_o;
    wire  [7:0]  data_o;
    wire         wb_ack_o, config_request_n_o, config_clock_o, user_startup_clock_o;
    wire         status_n, complete, init_done;
    int          miscompares = 0, n_checks = 0, sum;
    fpc_host #(.USR_MARGIN(1)) fpc_host_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .config_request_n_o,
        .status_open_drain_n_i(status_n), .config_complete_i(complete), .init_done_i(init_done),
        .config_clock_o, .data_o, .user_startup_clock_o);
    fpc_dev_model #(.IMG(IMG)) fpc_dev_model_i (.config_request_n_i(config_request_n_o),
        .config_clock_i(config_clock_o), .data_i(data_o), .user_startup_clock_i(user_startup_clock_o),
        .mode4x_i(m4), .use_init_i(ui), .autorst_i(ar), .err_i(err),
        .status_open_drain_n_o(status_n), .config_complete_o(complete), .init_done_o(init_done));
    initial forever #10 clk_i = ~clk_i;
    task automatic results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Classic single cycle; stalled data writes wait for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 3000);
        q = wb_dat_o;
        if (k == 3000) miscompares++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_state(input logic [6:0] st);
        int k = 0;
        do begin
            wb(1'b0, `FPC_ADR_STATUS, 32'h0, 4'hF);
            k++;
        end while (q[6:0] !== st && k < 2000);
    endtask
    // Whole image; the device takes all but the last byte
    task automatic load(input int r);
        logic [7:0] b;
        sum = 0;
        for (int i = 0; i < IMG; i++) begin
            b = 8'h11 * (i + 1) ^ r;
            wb(1'b1, `FPC_ADR_DATA, {24'h0, b}, 4'h1);
            if (i < IMG - 1) sum += b;
        end
    endtask
    task automatic start(input logic [31:0] c);
        wb(1'b1, `FPC_ADR_CTRL, c, 4'hF);
        wait_state(7'h08);
    endtask
    task automatic pulse_err;
        repeat (20) @(posedge clk_i);
        err <= 1'b1;
        repeat (8) @(posedge clk_i);
        err <= 1'b0;
    endtask
    initial begin
        #1000000;
        miscompares++;
        results;
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            {ui, m4} <= rows[r].mode[1:0];
            start({27'h0, rows[r].mode, 2'b01});
            load(r);
            wait_state(rows[r].exp_state);
            `FPC_CHK(q[6:0], rows[r].exp_state)
            `FPC_CHK(q[`FPC_ST_INIT_PIN], 1'b1)
            `FPC_CHK(fpc_dev_model_i.n_bytes, IMG - 1)
            `FPC_CHK(fpc_dev_model_i.sum, sum)
            wb(1'b0, `FPC_ADR_COUNT, 32'h0, 4'hF);
            if (!m4) `FPC_CHK(q, IMG)
            if (rows[r].mode == 3'b100) `FPC_CHK(fpc_dev_model_i.uclk_n >= 299, 1'b1)
        end
        // Error mid-load with auto-restart: host waits for status, no request pulse
        {ui, m4, ar} <= 3'b001;
        start(32'h21);
        wb(1'b1, `FPC_ADR_DATA, 32'h5A, 4'h1);
        wb(1'b1, `FPC_ADR_DATA, 32'hA5, 4'h1);
        pulse_err;
        wb(1'b0, `FPC_ADR_STATUS, 32'h0, 4'hF);
        `FPC_CHK(q[`FPC_ST_ERROR], 1'b1)
        `FPC_CHK(q[6:0], 7'h04)
        wait_state(7'h08);
        `FPC_CHK(config_request_n_o, 1'b1)
        load(7);
        wait_state(7'h20);
        `FPC_CHK(fpc_dev_model_i.n_bytes, IMG - 1)
        `FPC_CHK(q[`FPC_ST_ERROR], 1'b1)
        // Without auto-restart the host stops; a fresh start recovers
        ar <= 1'b0;
        start(32'h01);
        wb(1'b1, `FPC_ADR_DATA, 32'h3C, 4'h1);
        pulse_err;
        wait_state(7'h40);
        `FPC_CHK(q[6:0], 7'h40)
        start(32'h01);
        load(3);
        wait_state(7'h20);
        `FPC_CHK(q[`FPC_ST_ERROR], 1'b0)
        `FPC_CHK(fpc_dev_model_i.sum, sum)
        // Control byte lane, read-back and an unmapped place
        wb(1'b1, `FPC_ADR_CTRL, 32'h3C, 4'h0);
        wb(1'b0, `FPC_ADR_CTRL, 32'h0, 4'hF);
        `FPC_CHK(q, 32'h0)
        wb(1'b1, `FPC_ADR_CTRL, 32'h3C, 4'hF);
        wb(1'b0, `FPC_ADR_CTRL, 32'h0, 4'hF);
        `FPC_CHK(q, 32'h3C)
        wb(1'b1, 8'h10, 32'hFF, 4'hF);
        wb(1'b0, 8'h10, 32'h0, 4'hF);
        `FPC_CHK(q, 32'h0)
        // Abort in mid-load drops back to idle with the request low
        start(32'h01);
        wb(1'b1, `FPC_ADR_CTRL, 32'h02, 4'hF);
        wb(1'b1, `FPC_ADR_DATA, 32'h77, 4'h1);
        wb(1'b0, `FPC_ADR_STATUS, 32'h0, 4'hF);
        `FPC_CHK(q[6:0], 7'h01)
        `FPC_CHK(config_request_n_o, 1'b0)
        `FPC_CHK(q[`FPC_ST_HOLD_FULL], 1'b0)
        // Second reset in mid-load
        start(32'h01);
        wb(1'b1, `FPC_ADR_DATA, 32'h12, 4'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `FPC_CHK(config_request_n_o, 1'b0)
        `FPC_CHK(config_clock_o, 1'b0)
        wb(1'b0, `FPC_ADR_STATUS, 32'h0, 4'hF);
        `FPC_CHK(q[6:0], 7'h01)
        wb(1'b0, `FPC_ADR_CTRL, 32'h0, 4'hF);
        `FPC_CHK(q, 32'h0)
        results;
    end
endmodule // fast_parallel_config_port_test
